// File: design/dxcd_consts.svh
/*
 constant definitions for the mode register and command decode block.
 assumes it is included by bare name from the decode, lock and top design modules.
*/
// How it works
// - output mute bit disables data, both strobe polarities and extra read strobes.
// - topmost address bit used only on the byte-wide organisation.
// - mode set with select 0,1,0 loads second extended register from address.
// - mode register rewrites accepted in normal operation when all banks precharged.
// - bit seven enables hot refresh rate, only on extended temperature grades.
// - commands decoded from strobes and gate at rising edge; mode set, refresh.
// - activate and precharge decoded; address ten selects all banks; bank bits.
// - mode set select bits choose register, address bits are the opcode.
// - bursts of length four are never terminated or interrupted.
// - termination never affects decode and is off during self refresh.
// - self refresh and power down entered and exited by gate transitions.
// - wide part ignores topmost address bit on activate.
// - write, read, no operation and deselect decoded; address ten auto precharge.
// - loop off in self refresh, on after exit; 200 cycles before a read.
`ifndef DXCD_CONSTS_SVH
`define DXCD_CONSTS_SVH

`define DXCD_ADDR_W 15
`define DXCD_BANK_W 3
`define DXCD_NBANK 8
`define DXCD_SEL_MODE 3'h0
`define DXCD_SEL_EXT1 3'h1
`define DXCD_SEL_EXT2 3'h2
`define DXCD_SEL_EXT3 3'h3
`define DXCD_EXT1_EXTRA_READ_STROBE_BIT 11
`define DXCD_EXT1_MUTE_BIT 12
`define DXCD_EXT1_RTT_LO_BIT 2
`define DXCD_EXT1_RTT_HI_BIT 6
`define DXCD_EXT2_HOT_BIT 7
`define DXCD_AUTO_PRE_BIT 10
`define DXCD_TOP_ADDR_BIT 14
`define DXCD_LOCK_CYCLES 200
`define DXCD_LOCK_W 8
`define DXCD_BURST_FOUR 2'h0
`define DXCD_BURST_EIGHT 2'h1

`endif

// File: design/dxcd_pkg.sv
/*
 types for the mode register and command decode block.
 assumes nothing beyond the constants header.
*/
package dxcd_pkg;
	typedef enum logic [3:0] {
		DXCD_CMD_DESEL,
		DXCD_CMD_NOP,
		DXCD_CMD_MODE_SET,
		DXCD_CMD_REFRESH,
		DXCD_CMD_SELF_ENTER,
		DXCD_CMD_PRECHARGE,
		DXCD_CMD_ACTIVATE,
		DXCD_CMD_WRITE,
		DXCD_CMD_READ,
		DXCD_CMD_PD_ENTER,
		DXCD_CMD_WAKE,
		DXCD_CMD_ILLEGAL
	} dxcd_cmd_t;

	typedef enum logic [1:0] {
		DXCD_ST_AWAKE,
		DXCD_ST_POWER_DOWN,
		DXCD_ST_SELF_REFRESH
	} dxcd_state_t;
endpackage

// File: design/dxcd_decode.sv
/*
 registers the command pins and decodes one command per rising edge.
 assumes pins are synchronous to clk and driven to valid levels.
*/
`include "dxcd_consts.svh"

module dxcd_decode (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cke,
	input wire logic chip_sel_n,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [`DXCD_BANK_W-1:0] bank_sel,
	input wire logic [`DXCD_ADDR_W-1:0] addr,
	output dxcd_pkg::dxcd_cmd_t cmd_q,
	output logic [`DXCD_BANK_W-1:0] bank_q,
	output logic [`DXCD_ADDR_W-1:0] addr_q
);
	logic cke_prev_q;

	// --------------------------------------------------------------
	// command table; termination is not an input here
	// --------------------------------------------------------------
	function automatic dxcd_pkg::dxcd_cmd_t decode_cmd(input logic prev, input logic cur, input logic cs_n,
		input logic ras_n, input logic cas_n, input logic we_n);
		logic idle;
		idle = cs_n | (ras_n & cas_n & we_n);
		decode_cmd = dxcd_pkg::DXCD_CMD_ILLEGAL;
		if (!prev) begin
			decode_cmd = (cur && idle) ? dxcd_pkg::DXCD_CMD_WAKE : dxcd_pkg::DXCD_CMD_NOP;
		end else if (!cur) begin
			if (idle)
				decode_cmd = dxcd_pkg::DXCD_CMD_PD_ENTER;
			else if ({ras_n, cas_n, we_n} == 3'h1)
				decode_cmd = dxcd_pkg::DXCD_CMD_SELF_ENTER;
		end else if (cs_n) begin
			decode_cmd = dxcd_pkg::DXCD_CMD_DESEL;
		end else begin
			case ({ras_n, cas_n, we_n})
				3'h0: decode_cmd = dxcd_pkg::DXCD_CMD_MODE_SET;
				3'h1: decode_cmd = dxcd_pkg::DXCD_CMD_REFRESH;
				3'h2: decode_cmd = dxcd_pkg::DXCD_CMD_PRECHARGE;
				3'h3: decode_cmd = dxcd_pkg::DXCD_CMD_ACTIVATE;
				3'h4: decode_cmd = dxcd_pkg::DXCD_CMD_WRITE;
				3'h5: decode_cmd = dxcd_pkg::DXCD_CMD_READ;
				3'h7: decode_cmd = dxcd_pkg::DXCD_CMD_NOP;
				default: decode_cmd = dxcd_pkg::DXCD_CMD_ILLEGAL;
			endcase
		end
	endfunction

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cke_prev_q <= 1'b0;
		else
			cke_prev_q <= cke;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q <= dxcd_pkg::DXCD_CMD_DESEL;
			bank_q <= '0;
			addr_q <= '0;
		end else begin
			cmd_q <= decode_cmd(cke_prev_q, cke, chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n);
			bank_q <= bank_sel;
			addr_q <= addr;
		end
	end
endmodule

// File: design/dxcd_lock.sv
/*
 delay locked loop enable and the read hold-off counter.
 assumes loop_off is held high for the whole of self refresh.
*/
`include "dxcd_consts.svh"

module dxcd_lock (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic loop_off,
	output logic loop_en_q,
	output logic locked_q
);
	logic [`DXCD_LOCK_W-1:0] count_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			loop_en_q <= 1'b0;
			count_q <= '0;
			locked_q <= 1'b0;
		end else if (loop_off) begin
			loop_en_q <= 1'b0;
			count_q <= '0;
			locked_q <= 1'b0;
		end else begin
			loop_en_q <= 1'b1;
			if (count_q != `DXCD_LOCK_W'(`DXCD_LOCK_CYCLES - 1))
				count_q <= count_q + `DXCD_LOCK_W'(1);
			locked_q <= (count_q == `DXCD_LOCK_W'(`DXCD_LOCK_CYCLES - 1));
		end
	end

	lock_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(loop_off) |-> !locked_q [*8]) else $error("read allowed too soon after loop enable");
endmodule

// File: design/dxcd_top.sv
/*
 mode register capture, power state tracking and command acceptance for the
 memory device. assumes a controller that keeps its own timing and init rules.
*/
`include "dxcd_consts.svh"

module dxcd_top #(
	parameter bit WIDE_PART = 1'b0,
	parameter bit HOT_GRADE = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cke,
	input wire logic chip_sel_n,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [`DXCD_BANK_W-1:0] bank_sel,
	input wire logic [`DXCD_ADDR_W-1:0] addr,
	input wire logic die_termination,
	output logic [`DXCD_ADDR_W-1:0] mode_reg_q,
	output logic [`DXCD_ADDR_W-1:0] ext_mode_reg_one_q,
	output logic [`DXCD_ADDR_W-1:0] ext_mode_two_refresh_ctrl_q,
	output logic [`DXCD_ADDR_W-1:0] ext_mode_three_reserved_q,
	output logic hot_refresh_rate_q,
	output logic data_out_en_q,
	output logic strobe_out_en_q,
	output logic strobe_n_out_en_q,
	output logic extra_read_strobe_en_q,
	output logic term_en_q,
	output logic [`DXCD_NBANK-1:0] bank_open_q,
	output logic [`DXCD_ADDR_W-1:0] row_q,
	output logic [9:0] col_q,
	output logic [`DXCD_BANK_W-1:0] target_bank_q,
	output logic act_pulse_q,
	output logic pre_pulse_q,
	output logic rd_pulse_q,
	output logic wr_pulse_q,
	output logic auto_pre_q,
	output logic refresh_pulse_q,
	output logic mode_set_pulse_q,
	output logic cmd_reject_q,
	output logic self_refresh_q,
	output logic power_down_q,
	output logic loop_en_q,
	output logic read_ready_q
);
	dxcd_pkg::dxcd_cmd_t cmd;
	dxcd_pkg::dxcd_state_t state_q;
	logic [`DXCD_BANK_W-1:0] bank;
	logic [`DXCD_ADDR_W-1:0] addr_r;
	logic [`DXCD_ADDR_W-1:0] addr_eff;
	logic [1:0] burst_left_q;
	logic all_idle;
	logic awake;
	logic burst_busy;
	logic mode_ok;
	logic loop_off;

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	function automatic logic [`DXCD_ADDR_W-1:0] trim_top(input logic [`DXCD_ADDR_W-1:0] a);
		trim_top = a;
		if (WIDE_PART)
			trim_top[`DXCD_TOP_ADDR_BIT] = 1'b0;
	endfunction

	dxcd_decode u_decode (
		.clk(clk),
		.rst_n(rst_n),
		.cke(cke),
		.chip_sel_n(chip_sel_n),
		.row_strobe_n(row_strobe_n),
		.col_strobe_n(col_strobe_n),
		.write_strobe_n(write_strobe_n),
		.bank_sel(bank_sel),
		.addr(addr),
		.cmd_q(cmd),
		.bank_q(bank),
		.addr_q(addr_r)
	);

	assign addr_eff = trim_top(addr_r);
	assign all_idle = (bank_open_q == '0);
	assign awake = (state_q == dxcd_pkg::DXCD_ST_AWAKE);
	// the pulse cycle itself counts, so a back-to-back column command is held off too
	assign burst_busy = (burst_left_q != 2'h0) ||
		((rd_pulse_q || wr_pulse_q) && mode_reg_q[1:0] == `DXCD_BURST_FOUR);
	assign mode_ok = awake && all_idle && !burst_busy;
	assign loop_off = (state_q == dxcd_pkg::DXCD_ST_SELF_REFRESH);

	// --------------------------------------------------------------
	// power state
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= dxcd_pkg::DXCD_ST_AWAKE;
		end else begin
			case (state_q)
				dxcd_pkg::DXCD_ST_AWAKE: begin
					if (cmd == dxcd_pkg::DXCD_CMD_SELF_ENTER && all_idle && !burst_busy)
						state_q <= dxcd_pkg::DXCD_ST_SELF_REFRESH;
					else if (cmd == dxcd_pkg::DXCD_CMD_PD_ENTER && !burst_busy)
						state_q <= dxcd_pkg::DXCD_ST_POWER_DOWN;
				end
				dxcd_pkg::DXCD_ST_POWER_DOWN,
				dxcd_pkg::DXCD_ST_SELF_REFRESH: begin
					if (cmd == dxcd_pkg::DXCD_CMD_WAKE)
						state_q <= dxcd_pkg::DXCD_ST_AWAKE;
				end
				default: state_q <= dxcd_pkg::DXCD_ST_AWAKE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			self_refresh_q <= 1'b0;
			power_down_q <= 1'b0;
		end else begin
			self_refresh_q <= (state_q == dxcd_pkg::DXCD_ST_SELF_REFRESH);
			power_down_q <= (state_q == dxcd_pkg::DXCD_ST_POWER_DOWN);
		end
	end

	// --------------------------------------------------------------
	// mode registers
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg_q <= '0;
			ext_mode_reg_one_q <= '0;
			ext_mode_two_refresh_ctrl_q <= '0;
			ext_mode_three_reserved_q <= '0;
		end else if (cmd == dxcd_pkg::DXCD_CMD_MODE_SET && mode_ok) begin
			case (bank)
				`DXCD_SEL_MODE: mode_reg_q <= addr_eff;
				`DXCD_SEL_EXT1: ext_mode_reg_one_q <= addr_eff;
				`DXCD_SEL_EXT2: ext_mode_two_refresh_ctrl_q <= addr_eff;
				`DXCD_SEL_EXT3: ext_mode_three_reserved_q <= addr_eff;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			hot_refresh_rate_q <= 1'b0;
		else
			hot_refresh_rate_q <= HOT_GRADE && ext_mode_two_refresh_ctrl_q[`DXCD_EXT2_HOT_BIT];
	end

	// --------------------------------------------------------------
	// output enables and termination
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_out_en_q <= 1'b0;
			strobe_out_en_q <= 1'b0;
			strobe_n_out_en_q <= 1'b0;
			extra_read_strobe_en_q <= 1'b0;
		end else begin
			data_out_en_q <= !ext_mode_reg_one_q[`DXCD_EXT1_MUTE_BIT];
			strobe_out_en_q <= !ext_mode_reg_one_q[`DXCD_EXT1_MUTE_BIT];
			strobe_n_out_en_q <= !ext_mode_reg_one_q[`DXCD_EXT1_MUTE_BIT] &&
				!ext_mode_reg_one_q[`DXCD_AUTO_PRE_BIT];
			extra_read_strobe_en_q <= !ext_mode_reg_one_q[`DXCD_EXT1_MUTE_BIT] && !WIDE_PART &&
				ext_mode_reg_one_q[`DXCD_EXT1_EXTRA_READ_STROBE_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			term_en_q <= 1'b0;
		else
			term_en_q <= die_termination && !loop_off &&
				(ext_mode_reg_one_q[`DXCD_EXT1_RTT_LO_BIT] || ext_mode_reg_one_q[`DXCD_EXT1_RTT_HI_BIT]);
	end

	// --------------------------------------------------------------
	// bank state and command pulses
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bank_open_q <= '0;
		end else if (awake) begin
			if (cmd == dxcd_pkg::DXCD_CMD_ACTIVATE)
				bank_open_q[bank] <= 1'b1;
			else if (cmd == dxcd_pkg::DXCD_CMD_PRECHARGE && !burst_busy) begin
				if (addr_r[`DXCD_AUTO_PRE_BIT])
					bank_open_q <= '0;
				else
					bank_open_q[bank] <= 1'b0;
			end
		end
	end

	// a length four burst holds off any new column command for two cycles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			burst_left_q <= 2'h0;
		else if ((rd_pulse_q || wr_pulse_q) && mode_reg_q[1:0] == `DXCD_BURST_FOUR)
			burst_left_q <= 2'h1;
		else if (burst_busy)
			burst_left_q <= burst_left_q - 2'h1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			act_pulse_q <= 1'b0;
			pre_pulse_q <= 1'b0;
			rd_pulse_q <= 1'b0;
			wr_pulse_q <= 1'b0;
			refresh_pulse_q <= 1'b0;
			mode_set_pulse_q <= 1'b0;
			cmd_reject_q <= 1'b0;
			auto_pre_q <= 1'b0;
			target_bank_q <= '0;
			row_q <= '0;
			col_q <= '0;
		end else begin
			act_pulse_q <= awake && cmd == dxcd_pkg::DXCD_CMD_ACTIVATE;
			pre_pulse_q <= awake && cmd == dxcd_pkg::DXCD_CMD_PRECHARGE && !burst_busy;
			rd_pulse_q <= awake && cmd == dxcd_pkg::DXCD_CMD_READ && !burst_busy && read_ready_q;
			wr_pulse_q <= awake && cmd == dxcd_pkg::DXCD_CMD_WRITE && !burst_busy;
			refresh_pulse_q <= awake && cmd == dxcd_pkg::DXCD_CMD_REFRESH && all_idle;
			mode_set_pulse_q <= cmd == dxcd_pkg::DXCD_CMD_MODE_SET && mode_ok;
			cmd_reject_q <= cmd == dxcd_pkg::DXCD_CMD_ILLEGAL ||
				(cmd == dxcd_pkg::DXCD_CMD_MODE_SET && !mode_ok);
			auto_pre_q <= addr_r[`DXCD_AUTO_PRE_BIT];
			target_bank_q <= bank;
			if (cmd == dxcd_pkg::DXCD_CMD_ACTIVATE)
				row_q <= addr_eff;
			col_q <= addr_r[9:0];
		end
	end

	dxcd_lock u_lock (
		.clk(clk),
		.rst_n(rst_n),
		.loop_off(loop_off),
		.loop_en_q(loop_en_q),
		.locked_q(read_ready_q)
	);

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	sequence mset_cmd_s;
		cmd == dxcd_pkg::DXCD_CMD_MODE_SET && mode_ok && bank == `DXCD_SEL_EXT2;
	endsequence

	sequence mset_one_s;
		cmd == dxcd_pkg::DXCD_CMD_MODE_SET && mode_ok && bank == `DXCD_SEL_EXT1;
	endsequence

	sequence rd_cmd_s;
		awake && cmd == dxcd_pkg::DXCD_CMD_READ && !burst_busy && read_ready_q;
	endsequence

	sequence pd_cmd_s;
		awake && cmd == dxcd_pkg::DXCD_CMD_PD_ENTER && !burst_busy;
	endsequence

	ext_two_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		mset_cmd_s |=> ext_mode_two_refresh_ctrl_q == $past(addr_eff)) else $error("second register not loaded");
	ext_one_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		mset_one_s |=> ext_mode_reg_one_q == $past(addr_eff)) else $error("first register not loaded");
	mode_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
		cmd == dxcd_pkg::DXCD_CMD_MODE_SET && !all_idle |=> !mode_set_pulse_q) else $error("mode set with open bank");
	wide_top_a: assert property (@(posedge clk) disable iff (!rst_n)
		WIDE_PART |-> !row_q[`DXCD_TOP_ADDR_BIT]) else $error("top row bit used on wide part");
	mute_out_a: assert property (@(posedge clk) disable iff (!rst_n)
		ext_mode_reg_one_q[`DXCD_EXT1_MUTE_BIT] |=> !data_out_en_q && !strobe_out_en_q && !extra_read_strobe_en_q)
		else $error("outputs not muted");
	strobe_mute_a: assert property (@(posedge clk) disable iff (!rst_n)
		ext_mode_reg_one_q[`DXCD_EXT1_MUTE_BIT] |=> !strobe_n_out_en_q) else $error("inverted strobe not muted");
	hot_grade_a: assert property (@(posedge clk) disable iff (!rst_n)
		!HOT_GRADE |-> !hot_refresh_rate_q) else $error("hot refresh rate on a plain grade");
	term_self_a: assert property (@(posedge clk) disable iff (!rst_n)
		self_refresh_q |-> !term_en_q) else $error("termination during self refresh");
	self_enter_a: assert property (@(posedge clk) disable iff (!rst_n)
		awake && cmd == dxcd_pkg::DXCD_CMD_SELF_ENTER && all_idle && !burst_busy |=> ##1 self_refresh_q)
		else $error("self refresh not entered");
	pd_enter_a: assert property (@(posedge clk) disable iff (!rst_n)
		pd_cmd_s |=> ##1 power_down_q) else $error("power down not entered");
	burst_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		rd_pulse_q && mode_reg_q[1:0] == `DXCD_BURST_FOUR |=> !rd_pulse_q && !wr_pulse_q)
		else $error("burst of four interrupted");
	refresh_cmd_a: assert property (@(posedge clk) disable iff (!rst_n)
		awake && cmd == dxcd_pkg::DXCD_CMD_REFRESH && all_idle |=> refresh_pulse_q) else $error("refresh not decoded");
	read_cmd_a: assert property (@(posedge clk) disable iff (!rst_n)
		rd_cmd_s |=> rd_pulse_q && col_q == $past(addr_r[9:0])) else $error("read not decoded");
	write_cmd_a: assert property (@(posedge clk) disable iff (!rst_n)
		awake && cmd == dxcd_pkg::DXCD_CMD_WRITE && !burst_busy |=> wr_pulse_q &&
		auto_pre_q == $past(addr_r[`DXCD_AUTO_PRE_BIT])) else $error("write not decoded");
	pre_all_a: assert property (@(posedge clk) disable iff (!rst_n)
		awake && cmd == dxcd_pkg::DXCD_CMD_PRECHARGE && !burst_busy && addr_r[`DXCD_AUTO_PRE_BIT] |=>
		bank_open_q == '0) else $error("precharge all left a bank open");
	act_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
		awake && cmd == dxcd_pkg::DXCD_CMD_ACTIVATE |=> act_pulse_q && bank_open_q[target_bank_q])
		else $error("activate not decoded");
	read_early_a: assert property (@(posedge clk) disable iff (!rst_n)
		!read_ready_q |=> !rd_pulse_q) else $error("read taken before the loop settled");
	loop_self_a: assert property (@(posedge clk) disable iff (!rst_n)
		self_refresh_q |-> !loop_en_q) else $error("loop on in self refresh");
endmodule

// File: tb/dxcd_ctrl_model.sv
/*
 behavioural memory controller that drives the command, address and termination pins.
 assumes one bench process calls its tasks and clk runs free.
*/
module dxcd_ctrl_model #(
	parameter bit WIDE = 1'b0,
	parameter int MODE_SET_WAIT = 2
) (
	input wire logic clk,
	output logic cke,
	output logic chip_sel_n,
	output logic row_strobe_n,
	output logic col_strobe_n,
	output logic write_strobe_n,
	output logic [2:0] bank_sel,
	output logic [14:0] addr,
	output logic die_termination
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	initial begin
		cke = 1'b0;
		{chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n} = 4'hF;
		bank_sel = 3'h0;
		addr = 15'h0000;
		die_termination = 1'b0;
	end

	// one command per edge; mode set opcodes trimmed to legal values
	task automatic send(input logic c, input logic [3:0] pins, input logic [2:0] bank, input logic [14:0] a);
		logic [14:0] op;
		logic ck;
		op = a;
		ck = c;
		if (pins == 4'h0) begin
			ck = 1'b1;
			if (bank == 3'h1 && WIDE) op[11] = 1'b0;
			if (bank == 3'h1) op[9:7] = 3'h0;
			if (bank == 3'h2) op = op & 15'h0080;
			if (bank == 3'h3) op = 15'h0000;
		end
		@(posedge clk);
		#2;
		cke = ck;
		{chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n} = pins;
		bank_sel = bank;
		addr = op;
		if (pins == 4'h0) idle(MODE_SET_WAIT);
	endtask

	// idle keeps every pin at a valid level but never repeats the last address
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clk);
			#2;
			{chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n} = 4'h7;
			bank_sel = ~bank_sel;
			addr = ~addr;
		end
	endtask

	task automatic set_term(input logic v);
		@(posedge clk);
		#2;
		die_termination = v;
	endtask
endmodule

// File: tb/dxcd_top_test.sv
/*
 self-checking bench for the command decode and mode register block.
 assumes the controller model drives all pins; a second design copy runs the wide-part settings.
*/
module dxcd_top_test;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct {
		logic [3:0] pins;
		logic [2:0] bank;
		logic [14:0] a;
		logic [6:0] exp;
	} dxcd_row_t;

	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cke, chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n, die_termination;
	logic [2:0] bank_sel, target_bank_q;
	logic [14:0] addr, mode_reg_q, ext_mode_reg_one_q, ext_mode_two_refresh_ctrl_q, ext_mode_three_reserved_q, row_q;
	logic [7:0] bank_open_q;
	logic [9:0] col_q;
	logic hot_refresh_rate_q, data_out_en_q, strobe_out_en_q, strobe_n_out_en_q, extra_read_strobe_en_q;
	logic term_en_q, act_pulse_q, pre_pulse_q, rd_pulse_q, wr_pulse_q, auto_pre_q, refresh_pulse_q;
	logic mode_set_pulse_q, cmd_reject_q, self_refresh_q, power_down_q, loop_en_q, read_ready_q;
	logic [14:0] wide_row;
	logic wide_hot, wide_extra_rs;
	logic [6:0] seen = 7'h00;
	int fail_count = 0;
	int checked = 0;
	int cycles = 0;
	int t0;
	dxcd_row_t rows [11] = '{
		'{4'h0, 3'h2, 15'h0080, 7'h20},
		'{4'h0, 3'h3, 15'h0000, 7'h20},
		'{4'h0, 3'h1, 15'h0044, 7'h20},
		'{4'h3, 3'h1, 15'h7ABC, 7'h01},
		'{4'h5, 3'h1, 15'h0003, 7'h04},
		'{4'h4, 3'h1, 15'h0405, 7'h08},
		'{4'h2, 3'h0, 15'h0400, 7'h02},
		'{4'h1, 3'h0, 15'h0000, 7'h10},
		'{4'h7, 3'h5, 15'h7FFF, 7'h00},
		'{4'h8, 3'h0, 15'h0000, 7'h00},
		'{4'h6, 3'h0, 15'h0000, 7'h40}
	};

	always #20 clk = ~clk;

	// ----------------------------------------
	// design and controller
	// ----------------------------------------
	dxcd_top i_dut (
		.clk(clk),
		.rst_n(rst_n),
		.cke(cke),
		.chip_sel_n(chip_sel_n),
		.row_strobe_n(row_strobe_n),
		.col_strobe_n(col_strobe_n),
		.write_strobe_n(write_strobe_n),
		.bank_sel(bank_sel),
		.addr(addr),
		.die_termination(die_termination),
		.mode_reg_q(mode_reg_q),
		.ext_mode_reg_one_q(ext_mode_reg_one_q),
		.ext_mode_two_refresh_ctrl_q(ext_mode_two_refresh_ctrl_q),
		.ext_mode_three_reserved_q(ext_mode_three_reserved_q),
		.hot_refresh_rate_q(hot_refresh_rate_q),
		.data_out_en_q(data_out_en_q),
		.strobe_out_en_q(strobe_out_en_q),
		.strobe_n_out_en_q(strobe_n_out_en_q),
		.extra_read_strobe_en_q(extra_read_strobe_en_q),
		.term_en_q(term_en_q),
		.bank_open_q(bank_open_q),
		.row_q(row_q),
		.col_q(col_q),
		.target_bank_q(target_bank_q),
		.act_pulse_q(act_pulse_q),
		.pre_pulse_q(pre_pulse_q),
		.rd_pulse_q(rd_pulse_q),
		.wr_pulse_q(wr_pulse_q),
		.auto_pre_q(auto_pre_q),
		.refresh_pulse_q(refresh_pulse_q),
		.mode_set_pulse_q(mode_set_pulse_q),
		.cmd_reject_q(cmd_reject_q),
		.self_refresh_q(self_refresh_q),
		.power_down_q(power_down_q),
		.loop_en_q(loop_en_q),
		.read_ready_q(read_ready_q)
	);

	dxcd_top #(
		.WIDE_PART(1'b1),
		.HOT_GRADE(1'b0)
	) i_dut_wide (
		.clk(clk),
		.rst_n(rst_n),
		.cke(cke),
		.chip_sel_n(chip_sel_n),
		.row_strobe_n(row_strobe_n),
		.col_strobe_n(col_strobe_n),
		.write_strobe_n(write_strobe_n),
		.bank_sel(bank_sel),
		.addr(addr),
		.die_termination(die_termination),
		.mode_reg_q(),
		.ext_mode_reg_one_q(),
		.ext_mode_two_refresh_ctrl_q(),
		.ext_mode_three_reserved_q(),
		.hot_refresh_rate_q(wide_hot),
		.data_out_en_q(),
		.strobe_out_en_q(),
		.strobe_n_out_en_q(),
		.extra_read_strobe_en_q(wide_extra_rs),
		.term_en_q(),
		.bank_open_q(),
		.row_q(wide_row),
		.col_q(),
		.target_bank_q(),
		.act_pulse_q(),
		.pre_pulse_q(),
		.rd_pulse_q(),
		.wr_pulse_q(),
		.auto_pre_q(),
		.refresh_pulse_q(),
		.mode_set_pulse_q(),
		.cmd_reject_q(),
		.self_refresh_q(),
		.power_down_q(),
		.loop_en_q(),
		.read_ready_q()
	);

	dxcd_ctrl_model i_ctrl (
		.clk(clk),
		.cke(cke),
		.chip_sel_n(chip_sel_n),
		.row_strobe_n(row_strobe_n),
		.col_strobe_n(col_strobe_n),
		.write_strobe_n(write_strobe_n),
		.bank_sel(bank_sel),
		.addr(addr),
		.die_termination(die_termination)
	);

	// ----------------------------------------
	// monitors and helpers
	// ----------------------------------------
	always @(negedge clk) begin
		seen <= seen | {cmd_reject_q, mode_set_pulse_q, refresh_pulse_q, wr_pulse_q, rd_pulse_q, pre_pulse_q, act_pulse_q};
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			finish_test();
		end
	end

	task automatic check(input logic [14:0] got, input logic [14:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic run(input logic [3:0] pins, input logic [2:0] bank, input logic [14:0] a);
		seen = 7'h00;
		i_ctrl.send(1'b1, pins, bank, a);
		i_ctrl.idle(5);
	endtask

	// waits for read readiness and checks the hold-off measured from t0
	task automatic wait_ready();
		int d;
		for (int k = 0; k < 400 && read_ready_q !== 1'b1; k++) @(negedge clk);
		d = cycles - t0;
		check({14'h0000, d >= 200 && d <= 210}, 15'h0001);
	endtask

	task automatic finish_test();
		if (fail_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		i_ctrl.send(1'b1, 4'h7, 3'h0, 15'h0000);
		check({mode_reg_q[13:0], loop_en_q}, 15'h0000);
		rst_n = 1'b1;
		t0 = cycles;
		i_ctrl.set_term(1'b1);
		run(4'h5, 3'h0, 15'h0000);
		check({8'h00, seen}, 15'h0000);
		wait_ready();
		foreach (rows[i]) begin
			run(rows[i].pins, rows[i].bank, rows[i].a);
			check({8'h00, seen}, {8'h00, rows[i].exp});
		end
		check(row_q, 15'h7ABC);
		check(wide_row, 15'h3ABC);
		check({7'h00, bank_open_q}, 15'h0000);
		check(ext_mode_two_refresh_ctrl_q, 15'h0080);
		check(ext_mode_three_reserved_q ^ ext_mode_reg_one_q, 15'h0044);
		check({13'h0000, hot_refresh_rate_q, term_en_q}, 15'h0003);
		check({14'h0000, wide_hot}, 15'h0000);
		run(4'h0, 3'h1, 15'h1800);
		check({11'h000, data_out_en_q, strobe_out_en_q, strobe_n_out_en_q, extra_read_strobe_en_q}, 15'h0000);
		run(4'h0, 3'h1, 15'h0800);
		check({11'h000, data_out_en_q, strobe_out_en_q, strobe_n_out_en_q, extra_read_strobe_en_q}, 15'h000F);
		check({14'h0000, wide_extra_rs}, 15'h0000);
		run(4'h0, 3'h1, 15'h0444);
		check({11'h000, data_out_en_q, strobe_out_en_q, strobe_n_out_en_q, extra_read_strobe_en_q}, 15'h000C);
		// back-to-back precharge right after a burst-four read is dropped
		run(4'h3, 3'h3, 15'h0011);
		seen = 7'h00;
		i_ctrl.send(1'b1, 4'h5, 3'h3, 15'h0000);
		i_ctrl.send(1'b1, 4'h2, 3'h3, 15'h0000);
		i_ctrl.idle(5);
		check({8'h00, seen}, 15'h0004);
		run(4'h2, 3'h3, 15'h0000);
		check({8'h00, seen}, 15'h0002);
		run(4'h3, 3'h2, 15'h0001);
		run(4'h3, 3'h5, 15'h0002);
		check({7'h00, bank_open_q}, 15'h0024);
		run(4'h0, 3'h0, 15'h0003);
		check({seen, mode_reg_q[7:0]}, 15'h4000);
		run(4'h2, 3'h0, 15'h0400);
		check({7'h00, bank_open_q}, 15'h0000);
		run(4'h0, 3'h0, 15'h0003);
		check({seen, mode_reg_q[7:0]}, 15'h2003);
		// self refresh entry and exit
		i_ctrl.send(1'b0, 4'h1, 3'h0, 15'h0000);
		i_ctrl.idle(4);
		check({11'h000, self_refresh_q, loop_en_q, term_en_q, power_down_q}, 15'h0008);
		i_ctrl.send(1'b1, 4'h7, 3'h0, 15'h0000);
		t0 = cycles;
		i_ctrl.idle(4);
		check({12'h000, self_refresh_q, loop_en_q, read_ready_q}, 15'h0002);
		wait_ready();
		// power down entry and exit
		i_ctrl.send(1'b0, 4'h7, 3'h0, 15'h0000);
		i_ctrl.idle(4);
		check({13'h0000, power_down_q, self_refresh_q}, 15'h0002);
		i_ctrl.send(1'b1, 4'h8, 3'h0, 15'h0000);
		i_ctrl.idle(4);
		run(4'h1, 3'h0, 15'h0000);
		check({7'h00, power_down_q, seen}, 15'h0010);
		// second reset in mid-run, then the controller reinitialises
		rst_n = 1'b0;
		@(negedge clk);
		check(ext_mode_two_refresh_ctrl_q | mode_reg_q, 15'h0000);
		i_ctrl.idle(1);
		rst_n = 1'b1;
		i_ctrl.idle(2);
		check({13'h0000, loop_en_q, read_ready_q}, 15'h0002);
		run(4'h0, 3'h2, 15'h0080);
		check(ext_mode_two_refresh_ctrl_q, 15'h0080);
		finish_test();
	end
endmodule
